/* an_np_pkg.sv */
// Package for the partner ability snapshot and next-page register block.
// Assumes a 32-bit classic Wishbone slave with byte addresses 4 x index.
package an_np_pkg;

	// ****************************************
	// Register indices and address width
	// ****************************************
	localparam logic [11:0] IDX_PARTNER_LOW = 12'h205;
	localparam logic [11:0] IDX_PARTNER_MID = 12'h206;
	localparam logic [11:0] IDX_PARTNER_HIGH = 12'h207;
	localparam logic [11:0] IDX_NP_LOW = 12'h208;
	localparam logic [11:0] IDX_CTRL = 12'h300;
	localparam logic [11:0] IDX_LEVEL = 12'h301;
	localparam int ADDR_W = 14;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int MID_LONG_REACH = 14;
	localparam int MID_GIGABIT = 7;
	localparam int MID_SHORT_FD = 6;
	localparam int MID_FAST = 5;
	localparam int HIGH_EEE = 14;
	localparam int HIGH_LVL_CAP = 13;
	localparam int HIGH_LVL_REQ = 12;
	localparam int HIGH_SHORT_HD = 11;
	localparam int NP_MORE = 15;
	localparam int NP_ACK = 14;
	localparam int NP_ENC = 13;
	localparam int NP_COMPLY = 12;
	localparam int NP_TOGGLE = 11;
	localparam int CODE_W = 11;
	localparam int CTRL_AN_RESET = 0;
	localparam int CTRL_LOCAL_CAP = 1;
	localparam int CTRL_LOCAL_REQ = 2;

	// ****************************************
	// Masks and reset values
	// ****************************************
	localparam logic [15:0] MID_MASK = 16'h40e0;
	localparam logic [15:0] HIGH_MASK = 16'h7800;
	localparam logic [15:0] NP_LOW_RESET = 16'h2001;
	localparam logic [15:0] NP_LOW_WMASK = 16'hb7ff;
	localparam logic [15:0] ZERO16 = 16'h0000;
	localparam logic [10:0] CODE_NULL = 11'h001;
	localparam logic [10:0] CODE_OUI = 11'h005;
	localparam logic [10:0] CODE_DEV_ID = 11'h006;

	typedef struct packed {
		logic [15:0] low;
		logic [15:0] mid;
		logic [15:0] high;
	} partner_page_t;

	typedef struct packed {
		logic more_pages_flag;
		logic page_encoding_select;
		logic can_comply_flag;
		logic [CODE_W-1:0] page_code_field;
	} next_page_low_t;

endpackage : an_np_pkg

/* an_np_regs.sv */
// Partner base-page snapshot (mid/high) and local next-page low word.
// Assumes a classic Wishbone master and a live partner page from the AN core.
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps

module an_np_regs (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [an_np_pkg::ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	input wire an_np_pkg::partner_page_t partner_live_i,
	input wire logic np_ack_i,
	input wire logic np_ack_clear_i,
	output an_np_pkg::next_page_low_t next_page_o,
	output logic np_written_o,
	output logic high_level_o
);
	import an_np_pkg::*;

	// ****************************************
	// Bus decode
	// ****************************************
	logic req;
	logic [11:0] idx;
	logic hit_low;
	logic hit_mid;
	logic hit_high;
	logic hit_np;
	logic hit_ctrl;
	logic hit_level;
	logic mapped;
	logic wr_low_lanes;
	logic wr_byte0;

	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	assign idx = wb_adr_i[ADDR_W-1:2];
	always_comb begin
		hit_low = 1'b0;
		hit_mid = 1'b0;
		hit_high = 1'b0;
		hit_np = 1'b0;
		hit_ctrl = 1'b0;
		hit_level = 1'b0;
		unique case (idx)
			IDX_PARTNER_LOW: begin
				hit_low = 1'b1;
			end
			IDX_PARTNER_MID: begin
				hit_mid = 1'b1;
			end
			IDX_PARTNER_HIGH: begin
				hit_high = 1'b1;
			end
			IDX_NP_LOW: begin
				hit_np = 1'b1;
			end
			IDX_CTRL: begin
				hit_ctrl = 1'b1;
			end
			IDX_LEVEL: begin
				hit_level = 1'b1;
			end
			// Unmapped index: no hit, answered with an error
			default: begin
			end
		endcase
	end
	assign mapped = hit_low || hit_mid || hit_high || hit_np || hit_ctrl || hit_level;
	assign wr_low_lanes = req && wb_we_i && wb_sel_i[1:0] == 2'h3;
	assign wr_byte0 = req && wb_we_i && wb_sel_i[0];

	// ****************************************
	// Control: AN reset pulse, local level bits
	// ****************************************
	logic an_reset;
	logic local_cap;
	logic local_req;
	logic ctrl_write;

	assign ctrl_write = wr_byte0 && hit_ctrl;

	// One-cycle pulse; next-page defaults return on the following edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			an_reset <= 1'b0;
		end else begin
			an_reset <= ctrl_write && wb_dat_i[CTRL_AN_RESET];
		end
	end

	// ****************************************
	// Local transmit level controls
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			local_cap <= 1'b0;
		end else if (ctrl_write) begin
			local_cap <= wb_dat_i[CTRL_LOCAL_CAP];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			local_req <= 1'b0;
		end else if (ctrl_write) begin
			local_req <= wb_dat_i[CTRL_LOCAL_REQ];
		end
	end

	// ****************************************
	// Partner snapshot
	// ****************************************
	partner_page_t snap;
	logic capture;

	// Only a read of the low word takes a new snapshot
	assign capture = req && !wb_we_i && hit_low;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			snap.low <= ZERO16;
		end else if (capture) begin
			snap.low <= partner_live_i.low;
		end
	end

	// ****************************************
	// Snapshot bits
	// ****************************************
	// Defined ability bits follow the page, reserved bits stay zero
	for (genvar b = 0; b < 16; b++) begin : g_snap_bit
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				snap.mid[b] <= 1'b0;
				snap.high[b] <= 1'b0;
			end else if (capture) begin
				snap.mid[b] <= partner_live_i.mid[b] & MID_MASK[b];
				snap.high[b] <= partner_live_i.high[b] & HIGH_MASK[b];
			end
		end
	end

	// ****************************************
	// Transmit level resolution
	// ****************************************
	logic both_capable;
	logic any_request;

	// Either side lacking capability forces the low level
	assign both_capable = local_cap && snap.high[HIGH_LVL_CAP];
	assign any_request = local_req || snap.high[HIGH_LVL_REQ];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			high_level_o <= 1'b0;
		end else begin
			high_level_o <= both_capable && any_request;
		end
	end

	// ****************************************
	// Next-page low word
	// ****************************************
	logic np_write;
	logic np_default;

	assign np_write = wr_low_lanes && hit_np;
	// Power-up and autonegotiation reset share one default
	assign np_default = rst_i || an_reset;

	// Fields take a write only when both low byte lanes are selected
	always_ff @(posedge clk_i) begin
		if (np_default) begin
			next_page_o.more_pages_flag <= NP_LOW_RESET[NP_MORE];
		end else if (np_write) begin
			next_page_o.more_pages_flag <= wb_dat_i[NP_MORE];
		end
	end

	always_ff @(posedge clk_i) begin
		if (np_default) begin
			next_page_o.page_encoding_select <= NP_LOW_RESET[NP_ENC];
		end else if (np_write) begin
			next_page_o.page_encoding_select <= wb_dat_i[NP_ENC];
		end
	end

	always_ff @(posedge clk_i) begin
		if (np_default) begin
			next_page_o.can_comply_flag <= NP_LOW_RESET[NP_COMPLY];
		end else if (np_write) begin
			next_page_o.can_comply_flag <= wb_dat_i[NP_COMPLY];
		end
	end

	always_ff @(posedge clk_i) begin
		if (np_default) begin
			next_page_o.page_code_field <= NP_LOW_RESET[CODE_W-1:0];
		end else if (np_write) begin
			next_page_o.page_code_field <= wb_dat_i[CODE_W-1:0];
		end
	end

	// ****************************************
	// Acknowledge flag
	// ****************************************
	logic ack_flag;
	logic ack_clear_evt;

	// Hardware set wins over a clear in the same cycle
	assign ack_clear_evt = np_ack_clear_i && !np_ack_i;

	always_ff @(posedge clk_i) begin
		if (np_default) begin
			ack_flag <= 1'b0;
		end else if (np_ack_i) begin
			ack_flag <= 1'b1;
		end else if (ack_clear_evt) begin
			ack_flag <= 1'b0;
		end
	end

	// ****************************************
	// Next-page written strobe
	// ****************************************
	// Tells the AN core a new page is complete (next-page low word written)
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			np_written_o <= 1'b0;
		end else begin
			np_written_o <= np_write;
		end
	end

	// ****************************************
	// Read data and answer
	// ****************************************
	logic [15:0] np_read;
	logic [15:0] ctrl_read;
	logic [15:0] level_read;
	logic [15:0] rd_word;

	always_comb begin
		np_read = ZERO16;
		np_read[NP_MORE] = next_page_o.more_pages_flag;
		np_read[NP_ACK] = ack_flag;
		np_read[NP_ENC] = next_page_o.page_encoding_select;
		np_read[NP_COMPLY] = next_page_o.can_comply_flag;
		np_read[NP_TOGGLE] = 1'b0;
		np_read[CODE_W-1:0] = next_page_o.page_code_field;
	end

	always_comb begin
		ctrl_read = ZERO16;
		ctrl_read[CTRL_LOCAL_CAP] = local_cap;
		ctrl_read[CTRL_LOCAL_REQ] = local_req;
	end

	always_comb begin
		level_read = ZERO16;
		level_read[0] = high_level_o;
	end

	always_comb begin
		rd_word = ZERO16;
		if (hit_low) begin
			rd_word = partner_live_i.low;
		end else if (hit_mid) begin
			rd_word = snap.mid;
		end else if (hit_high) begin
			rd_word = snap.high;
		end else if (hit_np) begin
			rd_word = np_read;
		end else if (hit_ctrl) begin
			rd_word = ctrl_read;
		end else if (hit_level) begin
			rd_word = level_read;
		end
	end

	// ****************************************
	// Answer
	// ****************************************
	logic answer_ok;
	logic answer_err;
	logic read_take;

	assign answer_ok = req && mapped;
	// Unmapped indices answer with an error instead of a silent ack
	assign answer_err = req && !mapped;
	assign read_take = req && !wb_we_i && mapped;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= answer_ok;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_err_o <= 1'b0;
		end else begin
			wb_err_o <= answer_err;
		end
	end

	// Read data holds until the next read of a mapped index
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (read_take) begin
			wb_dat_o <= {16'h0000, rd_word};
		end
	end

endmodule : an_np_regs

/* remote_phy_model.sv */
// Remote PHY model: presents its advertised base page to the block.
// Assumes the bench chooses each page that the remote PHY advertises.
`timescale 1ns/1ps
module remote_phy_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire an_np_pkg::partner_page_t page_i,
	output an_np_pkg::partner_page_t page_o
);
	import an_np_pkg::*;
	always_ff @(posedge clk_i) begin
		page_o <= rst_i ? '0 : page_i;
	end
endmodule : remote_phy_model

/* an_np_checker.sv */
// Checker of bus answers and next-page port timing.
// Assumes a bind onto the register block.
`timescale 1ns/1ps
module an_np_checker (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [an_np_pkg::ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic wb_err_o,
	input wire an_np_pkg::next_page_low_t next_page_o,
	input wire logic np_written_o
);
	import an_np_pkg::*;
	logic req, np_wr, rd_ack;
	logic [13:0] np_fields;
	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
	assign np_wr = wb_we_i & (wb_adr_i == 14'h820) & (wb_sel_i[1:0] == 2'b11);
	assign rd_ack = wb_ack_o & ~wb_we_i;
	assign np_fields = {wb_dat_i[15], wb_dat_i[13:12], wb_dat_i[10:0]};
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ****************************************
	// Assertions
	// ****************************************
	a_one_answer: assert property (req |=> wb_ack_o ^ wb_err_o) else $error("no single answer");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o && !wb_err_o) else $error("ack too long");
	a_err_pulse: assert property (wb_err_o |=> !wb_err_o) else $error("err too long");
	a_upper_zero: assert property (rd_ack |-> wb_dat_o[31:16] == 16'h0000)
		else $error("upper read bits set");
	a_toggle_zero: assert property (rd_ack && wb_adr_i == 14'h820 |-> !wb_dat_o[NP_TOGGLE])
		else $error("toggle read nonzero");
	a_mid_reserved: assert property (rd_ack && wb_adr_i == 14'h818 |-> (wb_dat_o[15:0] & ~MID_MASK) == 16'h0000)
		else $error("mid reserved bits set");
	a_np_update: assert property (req && np_wr |=> next_page_o == $past(np_fields))
		else $error("next page not updated");
	a_np_written: assert property (req && np_wr |=> np_written_o)
		else $error("no written pulse");
	a_np_reset: assert property (disable iff (1'b0) rst_i |=> next_page_o == 14'h1001)
		else $error("next page reset wrong");
	c_capture: cover property (rd_ack && wb_adr_i == 14'h814);
	c_np_write: cover property (req && np_wr);
	c_unmapped: cover property (wb_err_o);
endmodule : an_np_checker

/* tb.sv */
// Bench for the partner snapshot and next-page register block.
// Assumes the remote PHY model and the bound checker.
`timescale 1ns/1ps
module tb;
	import an_np_pkg::*;
	logic clk_i, rst_i, cyc, stb, we, ack, err, ack_set, ack_clr, nw, lvl, last_err;
	logic [ADDR_W-1:0] adr;
	logic [3:0] sel, k;
	logic [31:0] wdat, rdat, rd;
	logic [15:0] d;
	partner_page_t live, pick, snap;
	next_page_low_t np;
	int num_errors = 0, checked = 0, seed = 91684, i;
	an_np_regs uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.wb_err_o(err), .partner_live_i(live), .np_ack_i(ack_set), .np_ack_clear_i(ack_clr),
		.next_page_o(np), .np_written_o(nw), .high_level_o(lvl));
	remote_phy_model peer (.clk_i(clk_i), .rst_i(rst_i), .page_i(pick), .page_o(live));
	function automatic logic [31:0] np_read(logic [15:0] v, logic a);
		return {16'h0, (v & NP_LOW_WMASK) | {1'b0, a, 14'h0}};
	endfunction : np_read
	function automatic logic [31:0] level(logic lc, logic lr, logic pc, logic pr);
		return {31'h0, lc & pc & (lr | pr)};
	endfunction : level
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic bus(input logic w, input logic [13:0] a, input logic [31:0] v, input logic [3:0] s);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= v;
		sel <= s;
		@(posedge clk_i);
		while (ack !== 1'b1 && err !== 1'b1) @(posedge clk_i);
		rd = rdat;
		last_err = err;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : bus
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : finish_test
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	initial begin
		#200000;
		num_errors++;
		finish_test;
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{rst_i, cyc, stb, we, ack_set, ack_clr, adr, sel, wdat, pick} = '0;
		rst_i = 1'b1;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(0, 14'h820, 0, 4'hf);
		check("np reset", rd, 32'h2001);
		bus(0, 14'h81c, 0, 4'hf);
		check("high reset", rd, 0);
		bus(0, 14'h818, 0, 4'hf);
		check("mid reset", rd, 0);
		for (i = 0; i < 24; i++) begin
			k = i[3:0];
			snap = {16'($random(seed)), 16'($random(seed)), 16'($random(seed))};
			if (i < 16) snap.high[13:12] = {k[1], k[3]};
			pick <= snap;
			bus(1, 14'hc00, {29'h0, k[2], k[0], 1'b0}, 4'h1);
			bus(0, 14'h814, 0, 4'hf);
			pick <= ~snap;
			bus(1, 14'h818, 32'hffffffff, 4'hf);
			bus(0, 14'h818, 0, 4'hf);
			check("mid", rd, {16'h0, snap.mid & MID_MASK});
			bus(0, 14'h81c, 0, 4'hf);
			check("high", rd, {16'h0, snap.high & HIGH_MASK});
			bus(0, 14'hc04, 0, 4'hf);
			check("level", rd, level(k[0], k[2], snap.high[13], snap.high[12]));
			check("level pin", 32'(lvl), level(k[0], k[2], snap.high[13], snap.high[12]));
		end
		for (i = 0; i < 8; i++) begin
			d = 16'($random(seed));
			if (i < 3) d[10:0] = (i == 0) ? CODE_NULL : (i == 1) ? CODE_OUI : CODE_DEV_ID;
			d[13] = i[0];
			bus(1, 14'h820, {16'h0, d}, 4'h3);
			check("np port", 32'(np), 32'({d[15], d[13:12], d[10:0]}));
			bus(1, 14'h820, {16'h0, ~d}, 4'h1);
			bus(0, 14'h820, 0, 4'hf);
			check("np low", rd, np_read(d, 1'b0));
		end
		ack_set <= 1'b1;
		@(posedge clk_i);
		ack_set <= 1'b0;
		bus(1, 14'h820, {16'h0, d & 16'hbfff}, 4'h3);
		bus(0, 14'h820, 0, 4'hf);
		check("np ack set", rd, np_read(d, 1'b1));
		ack_clr <= 1'b1;
		@(posedge clk_i);
		ack_clr <= 1'b0;
		bus(0, 14'h820, 0, 4'hf);
		check("np ack clear", rd, np_read(d, 1'b0));
		bus(1, 14'hc00, 32'h1, 4'h1);
		bus(0, 14'h820, 0, 4'hf);
		check("np an reset", rd, 32'h2001);
		bus(0, 14'h0100, 0, 4'hf);
		check("unmapped err", 32'(last_err), 32'h1);
		finish_test;
	end
endmodule : tb
bind an_np_regs an_np_checker chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
	.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .next_page_o, .np_written_o);
